// ===== src/ptl_tag_core.sv
// Behaviour
// RULE1 - thirty-two blocks of thirty-two bits
// RULE2 - blocks 0-2 operating, 3-31 user data
// RULE3 - block 1 holds fixed identifier
// RULE4 - whole-block writes except identifier block
// RULE5 - block protection; block 0 bits 30,31 free
// RULE6 - sixteen-bit CRC kept per block
// RULE7 - tag speaks first: answer at power-up
// RULE8 - reader speaks first: silent until command
// RULE9 - block 0 bits 30,31 pick talk order
// RULE10 - downlink is 1-of-16 pulse position
// RULE11 - uplink Manchester at 70 kbit/s
// RULE12 - calibration pulse sets decoder timing
// RULE13 - modulation transistor on/off per coded bit
// RULE14 - modulate only in own time slot
// RULE15 - bit 31 selects request or bypass command
// RULE16 - bit 30 set means tag speaks first; code also needs bit 31 set
// RULE17 - listen 1 ms after fast read answer
// RULE18 - sleep match code: sleep until power loss
// RULE19 - protected or identifier writes change nothing; code still writes bits 31:30 of a locked block 0

module ptl_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
)(
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             valid_in,
	input  wire logic [WIDTH-1:0] data_in,
	output logic                  ready_out,
	output logic                  valid_out,
	output logic [WIDTH-1:0]      data_out,
	input  wire logic             ready_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
	} ptl_fifo_state_type;

	ptl_fifo_state_type s;
	ptl_fifo_state_type n;
	logic               push;
	logic               pop;

	assign ready_out = (s.count != CW'(DEPTH));
	assign valid_out = (s.count != '0);
	assign data_out  = s.mem[s.rd_ptr];

	always_comb begin
		n = s;
		push = valid_in & ready_out;
		pop  = valid_out & ready_in;
		if (push) begin
			n.mem[s.wr_ptr] = data_in;
			n.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
		end
		if (pop) begin
			n.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			n.count = s.count + 1'b1;
		end else if (pop && !push) begin
			n.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule : ptl_fifo

module ptl_tag_core #(
	parameter int          LISTEN_CYCLES = ptl_pkg::LISTEN_CYC,
	parameter logic [31:0] TAG_ID        = ptl_pkg::TAG_ID_DEFAULT
)(
	input  wire logic                     clk_in,
	input  wire logic                     reset_in,
	input  wire logic                     downlink_pulse_in,
	input  wire ptl_pkg::ptl_bus_req_type bus_in,
	output logic [31:0]                   bus_rdata_out,
	output logic                          modulate_out,
	output logic                          asleep_out
);
	typedef struct packed {
		ptl_pkg::ptl_state_type st;
		ptl_pkg::ptl_state_type ret;
		ptl_pkg::ptl_dec_type   dec;
		logic [31:0][31:0]      mem;
		logic [31:0][15:0]      crc;
		logic [31:0]            lock;
		logic                   sync1;
		logic                   sync2;
		logic                   prev;
		logic [11:0]            cal;
		logic [11:0]            tick;
		logic [4:0]             sym_slot;
		logic [3:0]             op;
		logic [3:0]             need;
		logic [39:0]            args;
		logic [159:0]           tx;
		logic [7:0]             tx_bits;
		logic                   half;
		logic [9:0]             bit_tmr;
		logic [11:0]            wait_halves;
		logic [19:0]            listen;
		logic                   boot;
		logic                   heard;
		logic                   overrun;
		logic                   mod;
		logic                   ctrl_ovr;
		logic [3:0]             ctrl_slot;
		logic [4:0]             sel;
		logic [31:0]            rdata;
	} ptl_core_type;

	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		logic        fb;
		c = ptl_pkg::CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ ptl_pkg::CRC_POLY;
			end
		end
		return c;
	endfunction : crc16

	function automatic logic [3:0] cmd_len(input logic [3:0] op);
		case (op)
			ptl_pkg::OP_READ_BLOCK:  cmd_len = ptl_pkg::LEN_BLOCK;
			ptl_pkg::OP_LOCK_BLOCK:  cmd_len = ptl_pkg::LEN_BLOCK;
			ptl_pkg::OP_WRITE_BLOCK: cmd_len = ptl_pkg::LEN_WRITE;
			default:                 cmd_len = ptl_pkg::LEN_ONE;
		endcase
	endfunction : cmd_len

	// power-up image: memory defaults and matching CRCs
	function automatic ptl_core_type init_state();
		ptl_core_type r;
		r = '0;
		r.mem[ptl_pkg::CFG_BLOCK] = ptl_pkg::CFG_RESET;
		r.mem[ptl_pkg::ID_BLOCK]  = TAG_ID;
		for (int k = 0; k < ptl_pkg::NUM_BLOCKS; k++) begin
			r.crc[k] = crc16(r.mem[k]);
		end
		r.lock = ptl_pkg::LOCK_RESET;
		r.st   = ptl_pkg::ST_IDLE;
		r.ret  = ptl_pkg::ST_IDLE;
		r.dec  = ptl_pkg::DEC_IDLE;
		r.boot = 1'b1;
		return r;
	endfunction : init_state

	localparam ptl_core_type RESET_STATE = init_state();

	// power-up contents; later field losses keep the blocks
	ptl_core_type s = RESET_STATE;
	ptl_core_type n;
	ptl_core_type rst_v;
	logic         dec_push;
	logic [3:0]   dec_nib;
	logic         fifo_ready;
	logic         fifo_valid;
	logic [3:0]   fifo_nib;
	logic         cmd_ready;
	logic         pop;
	logic         exec;

	ptl_fifo #(
		.WIDTH (ptl_pkg::NIB_W),
		.DEPTH (ptl_pkg::FIFO_DEPTH)
	) u_nib_fifo (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.valid_in  (dec_push),
		.data_in   (dec_nib),
		.ready_out (fifo_ready),
		.valid_out (fifo_valid),
		.data_out  (fifo_nib),
		.ready_in  (cmd_ready)
	);

	assign bus_rdata_out = s.rdata;
	assign modulate_out  = s.mod;
	assign asleep_out    = (s.st == ptl_pkg::ST_SLEEP);

	always_comb begin
		logic        rise;
		logic [3:0]  op_x;
		logic [39:0] args_x;
		logic [4:0]  blk;
		logic [31:0] newv;
		logic [3:0]  my_slot;
		logic        frr_mode;
		rise     = s.sync2 & ~s.prev;
		op_x     = '0;
		args_x   = '0;
		blk      = '0;
		newv     = '0;
		frr_mode = s.mem[ptl_pkg::CFG_BLOCK][ptl_pkg::FR_BIT];
		my_slot  = s.ctrl_ovr ? s.ctrl_slot
			: s.mem[ptl_pkg::ID_BLOCK][3:0];
		n        = s;
		dec_push = 1'b0;
		dec_nib  = s.sym_slot[3:0];
		exec     = 1'b0;
		// stall the decoder fifo while the uplink is busy
		cmd_ready = (s.st != ptl_pkg::ST_SEND)
			&& (s.st != ptl_pkg::ST_SLOT_WAIT) && !s.boot;
		pop = fifo_valid & cmd_ready;

		// register port
		n.rdata = '0;
		if (bus_in.wr) begin
			case (bus_in.addr)
				ptl_pkg::REG_CTRL: begin
					n.ctrl_slot = bus_in.wdata[3:0];
					n.ctrl_ovr  = bus_in.wdata[ptl_pkg::CTRL_OVR_BIT];
					if (bus_in.wdata[ptl_pkg::CTRL_CLR_BIT]) begin
						n.overrun = 1'b0;
					end
				end
				ptl_pkg::REG_SEL: n.sel = bus_in.wdata[4:0];
				default: ;
			endcase
		end
		if (bus_in.rd) begin
			case (bus_in.addr)
				ptl_pkg::REG_CTRL:   n.rdata = {27'h0, s.ctrl_ovr, s.ctrl_slot};
				ptl_pkg::REG_STATUS: n.rdata = {26'h0, s.heard, s.overrun,
					asleep_out, s.st};
				ptl_pkg::REG_SEL:    n.rdata = {27'h0, s.sel};
				ptl_pkg::REG_DATA:   n.rdata = s.mem[s.sel];
				default:             n.rdata = '0;
			endcase
		end

		// downlink pulse position decoder
		n.sync1 = downlink_pulse_in;
		n.sync2 = s.sync1;
		n.prev  = s.sync2;
		case (s.dec)
			ptl_pkg::DEC_IDLE: begin
				if (rise) begin
					n.dec  = ptl_pkg::DEC_CAL;
					n.tick = '0;
				end
			end
			ptl_pkg::DEC_CAL: begin
				n.tick = s.tick + 1'b1;
				if (rise && s.tick != '0) begin
					n.cal      = s.tick; // RULE12
					n.tick     = '0;
					n.sym_slot = '0;
					n.dec      = ptl_pkg::DEC_SYM;
				end else if (&s.tick) begin
					n.dec = ptl_pkg::DEC_IDLE;
				end
			end
			ptl_pkg::DEC_SYM: begin
				n.tick = s.tick + 1'b1;
				if (s.tick == s.cal) begin
					n.tick     = '0;
					n.sym_slot = s.sym_slot + 1'b1;
				end
				if (rise) begin
					// slot index of the pulse is the nibble
					dec_push   = (s.sym_slot < 5'(ptl_pkg::SLOTS)); // RULE10
					n.tick     = '0;
					n.sym_slot = '0;
				end else if (s.sym_slot == 5'(ptl_pkg::SLOTS + 1)) begin
					// frame over: next command needs fresh calibration
					n.dec = ptl_pkg::DEC_IDLE; // RULE12
				end
			end
			default: n.dec = ptl_pkg::DEC_IDLE;
		endcase
		if (dec_push && !fifo_ready) begin
			n.overrun = 1'b1;
		end

		// command assembly
		if (pop) begin
			n.heard = 1'b1;
			if (s.need == '0) begin
				op_x   = fifo_nib;
				args_x = s.args;
				n.op   = fifo_nib;
				n.need = cmd_len(fifo_nib) - 1'b1;
				exec   = (cmd_len(fifo_nib) == ptl_pkg::LEN_ONE);
			end else begin
				op_x   = s.op;
				args_x = {s.args[35:0], fifo_nib};
				n.args = args_x;
				n.need = s.need - 1'b1;
				exec   = (s.need == 4'h1);
			end
		end

		// uplink timing and state
		case (s.st)
			ptl_pkg::ST_IDLE: begin
				if (s.boot) begin
					n.boot = 1'b0;
					if (frr_mode
						&& s.mem[ptl_pkg::CFG_BLOCK][ptl_pkg::TF_BIT]) begin // RULE9
						n.tx      = {s.mem[ptl_pkg::ID_BLOCK], s.mem[3], s.mem[4],
							s.mem[5], 32'h0};
						n.tx_bits = 8'(ptl_pkg::FRR_BITS);
						n.bit_tmr = '0;
						n.half    = 1'b0;
						n.st      = ptl_pkg::ST_SEND; // RULE7 RULE16
						n.ret     = ptl_pkg::ST_LISTEN;
					end
				end
			end
			ptl_pkg::ST_SLOT_WAIT, ptl_pkg::ST_SEND: begin
				n.bit_tmr = s.bit_tmr + 1'b1;
				if (s.bit_tmr == 10'(ptl_pkg::HALF_BIT_CYC - 1)) begin // RULE11
					n.bit_tmr = '0;
					if (s.st == ptl_pkg::ST_SLOT_WAIT) begin
						n.wait_halves = s.wait_halves - 1'b1;
						if (s.wait_halves == '0) begin
							n.st   = ptl_pkg::ST_SEND; // RULE14
							n.half = 1'b0;
						end
					end else begin
						n.half = ~s.half;
						if (s.half) begin
							n.tx      = {s.tx[158:0], 1'b0};
							n.tx_bits = s.tx_bits - 1'b1;
							if (s.tx_bits == 8'h1) begin
								n.st     = s.ret;
								n.listen = '0;
							end
						end
					end
				end
			end
			ptl_pkg::ST_LISTEN: begin
				n.listen = s.listen + 1'b1;
				if (s.listen == 20'(LISTEN_CYCLES - 1)) begin
					n.st = ptl_pkg::ST_IDLE; // RULE17
				end
			end
			default: ;
		endcase

		// command execution; sleep ignores everything
		if (exec && s.st != ptl_pkg::ST_SLEEP) begin // RULE18
			blk = (op_x == ptl_pkg::OP_WRITE_BLOCK) ? args_x[36:32]
				: args_x[4:0];
			case (op_x)
				ptl_pkg::OP_FAST_READ_REQUEST: begin
					if (frr_mode && (s.st == ptl_pkg::ST_IDLE
						|| s.st == ptl_pkg::ST_LISTEN)) begin // RULE15 RULE8
						n.tx          = {s.mem[ptl_pkg::ID_BLOCK], s.mem[3],
							s.mem[4], s.mem[5], 32'h0};
						n.tx_bits     = 8'(ptl_pkg::FRR_BITS);
						n.wait_halves = 12'(my_slot) * 12'(ptl_pkg::SLOT_HALVES);
						n.bit_tmr     = '0;
						n.st          = ptl_pkg::ST_SLOT_WAIT; // RULE14
						n.ret         = ptl_pkg::ST_LISTEN;
					end
				end
				ptl_pkg::OP_FAST_READ_BYPASS: begin
					if (!frr_mode && s.st == ptl_pkg::ST_IDLE) begin // RULE15
						n.tx      = {s.mem[ptl_pkg::ID_BLOCK], 128'h0};
						n.tx_bits = 8'(ptl_pkg::FRB_BITS);
						n.bit_tmr = '0;
						n.half    = 1'b0;
						n.st      = ptl_pkg::ST_SEND;
						n.ret     = ptl_pkg::ST_LISTEN;
					end
				end
				ptl_pkg::OP_SLEEP_MATCH_CODE: begin
					if (s.st == ptl_pkg::ST_LISTEN) begin
						n.st = ptl_pkg::ST_SLEEP; // RULE18
					end
				end
				ptl_pkg::OP_SELECT_MATCH_CODE: begin
					if (s.st == ptl_pkg::ST_LISTEN) begin
						n.st = ptl_pkg::ST_SELECTED;
					end
				end
				ptl_pkg::OP_READ_BLOCK, ptl_pkg::OP_WRITE_BLOCK: begin
					if (s.st == ptl_pkg::ST_SELECTED) begin
						newv = s.mem[blk];
						if (op_x == ptl_pkg::OP_WRITE_BLOCK
							&& blk != 5'(ptl_pkg::ID_BLOCK)) begin // RULE3 RULE4
							if (!s.lock[blk]) begin
								newv = args_x[31:0]; // RULE2
							end else if (blk == 5'(ptl_pkg::CFG_BLOCK)) begin
								newv[31:30] = args_x[31:30]; // RULE5
							end // RULE19
							n.mem[blk] = newv; // RULE1
							n.crc[blk] = crc16(newv); // RULE6
						end
						n.tx      = {newv, crc16(newv), 112'h0};
						n.tx_bits = 8'(ptl_pkg::BLK_RESP_BITS);
						n.bit_tmr = '0;
						n.half    = 1'b0;
						n.st      = ptl_pkg::ST_SEND;
						n.ret     = ptl_pkg::ST_SELECTED;
					end
				end
				ptl_pkg::OP_LOCK_BLOCK: begin
					if (s.st == ptl_pkg::ST_SELECTED) begin
						n.lock[blk] = 1'b1; // RULE5
					end
				end
				ptl_pkg::OP_END: begin
					if (s.st == ptl_pkg::ST_SELECTED) begin
						n.st = ptl_pkg::ST_SLEEP;
					end
				end
				default: ;
			endcase
		end

		// manchester: first half is the bit, second its inverse
		n.mod = (n.st == ptl_pkg::ST_SEND) & (n.tx[159] ^ n.half); // RULE13
	end

	// blocks and crc are nonvolatile: only the rest restarts
	always_comb begin
		rst_v     = RESET_STATE;
		rst_v.mem = s.mem; // RULE1
		rst_v.crc = s.crc;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s <= rst_v;
		end else begin
			s <= n;
		end
	end

	logic [29:0] cfg_low;
	assign cfg_low = s.mem[ptl_pkg::CFG_BLOCK][29:0];

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_mod_slot_quiet: assert property ( // RULE14
		(s.st != ptl_pkg::ST_SEND) |-> !s.mod)
		else $error("modulation outside own send window");
	a_id_block_fixed: assert property ( // RULE3
		$stable(s.mem[ptl_pkg::ID_BLOCK]))
		else $error("identifier block changed");
	a_crc_tracks_data: assert property ( // RULE6
		s.crc[s.sel] == crc16(s.mem[s.sel]))
		else $error("stored crc does not match block");
	a_sleep_holds: assert property ( // RULE18
		(s.st == ptl_pkg::ST_SLEEP) |=> (s.st == ptl_pkg::ST_SLEEP))
		else $error("tag woke from sleep");
	a_talk_order_silent: assert property ( // RULE8
		(s.st == ptl_pkg::ST_SEND && !s.heard)
		|-> (s.mem[0][ptl_pkg::TF_BIT] && s.mem[0][ptl_pkg::FR_BIT]))
		else $error("uplink before any command");
	a_ttf_boot_send: assert property ( // RULE7
		($fell(reset_in) && s.mem[0][ptl_pkg::TF_BIT]
			&& s.mem[0][ptl_pkg::FR_BIT]) |=> (s.st == ptl_pkg::ST_SEND))
		else $error("no answer at power-up");
	a_listen_window: assert property ( // RULE17
		(s.st == ptl_pkg::ST_LISTEN && s.listen == 20'(LISTEN_CYCLES - 1)
			&& !exec) |=> (s.st == ptl_pkg::ST_IDLE))
		else $error("listen window not closed on time");
	a_cfg_low_locked: assert property ( // RULE5
		s.lock[0] |=> (cfg_low == $past(cfg_low)))
		else $error("protected config bits changed");
	a_mid_bit_edge: assert property ( // RULE11
		(s.st == ptl_pkg::ST_SEND && $past(s.st) == ptl_pkg::ST_SEND
			&& $changed(s.mod)) |-> (s.bit_tmr == '0))
		else $error("modulation edge off half-bit grid");
	a_mode_bypass_ignored: assert property ( // RULE15
		(exec && s.need == 4'h0 && fifo_nib == ptl_pkg::OP_FAST_READ_BYPASS
			&& s.mem[0][ptl_pkg::FR_BIT] && s.st == ptl_pkg::ST_IDLE)
		|=> (s.st == ptl_pkg::ST_IDLE))
		else $error("bypass command answered in request mode");
endmodule : ptl_tag_core

// ===== src/ptl_pkg.sv
package ptl_pkg;

	localparam int CLK_HZ           = 40_000_000;
	localparam int BIT_RATE_HZ      = 70_000;
	localparam int HALF_BIT_CYC     = CLK_HZ / (2 * BIT_RATE_HZ);
	localparam int LISTEN_US        = 1000;
	localparam int LISTEN_CYC       = (CLK_HZ / 1_000_000) * LISTEN_US;

	localparam int NUM_BLOCKS       = 32;
	localparam int BLOCK_W          = 32;
	localparam int CRC_W            = 16;
	localparam int CFG_BLOCK        = 0;
	localparam int ID_BLOCK         = 1;
	localparam int FIRST_USER_BLOCK = 3;
	localparam int FR_BIT           = 31;
	localparam int TF_BIT           = 30;

	localparam int SLOTS            = 16;
	localparam int NIB_W            = 4;
	localparam int RESP_W           = 160;
	localparam int FRR_BITS         = 128;
	localparam int FRB_BITS         = 32;
	localparam int BLK_RESP_BITS    = 48;
	localparam int SLOT_HALVES      = 2 * FRR_BITS;
	localparam int FIFO_DEPTH       = 8;

	localparam logic [15:0] CRC_INIT       = 16'hffff;
	localparam logic [15:0] CRC_POLY       = 16'h1021;
	localparam logic [31:0] CFG_RESET      = 32'h8000_0000;
	// arbitrary neutral identifier
	localparam logic [31:0] TAG_ID_DEFAULT = 32'h5a5a_0001;
	localparam logic [31:0] LOCK_RESET     = 32'h0000_0002;

	localparam logic [3:0] OP_FAST_READ_REQUEST = 4'h1;
	localparam logic [3:0] OP_FAST_READ_BYPASS  = 4'h2;
	localparam logic [3:0] OP_SLEEP_MATCH_CODE  = 4'h3;
	localparam logic [3:0] OP_SELECT_MATCH_CODE = 4'h4;
	localparam logic [3:0] OP_READ_BLOCK        = 4'h5;
	localparam logic [3:0] OP_WRITE_BLOCK       = 4'h6;
	localparam logic [3:0] OP_END               = 4'h7;
	localparam logic [3:0] OP_LOCK_BLOCK        = 4'h8;
	localparam logic [3:0] LEN_ONE              = 4'h1;
	localparam logic [3:0] LEN_BLOCK            = 4'h3;
	localparam logic [3:0] LEN_WRITE            = 4'hb;

	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_SEL    = 4'h8;
	localparam logic [3:0] REG_DATA   = 4'hc;
	localparam int CTRL_OVR_BIT = 4;
	localparam int CTRL_CLR_BIT = 8;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SLOT_WAIT, ST_SEND, ST_LISTEN, ST_SELECTED, ST_SLEEP
	} ptl_state_type;

	typedef enum logic [1:0] {DEC_IDLE, DEC_CAL, DEC_SYM} ptl_dec_type;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} ptl_bus_req_type;

endpackage : ptl_pkg

// ===== verif/ptl_reader_model.sv
module ptl_reader_model (
	input  wire logic clk_in,
	input  wire logic modulate_in,
	output logic      pulse_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// slot is CAL+1 cycles; pulses land mid-slot to absorb sync delay
	localparam int CAL  = 15;
	localparam int HALF = ptl_pkg::HALF_BIT_CYC;

	initial pulse_out = 1'b0;

	// rising edges are w+2 cycles apart
	task automatic gap(input int w);
		repeat (w) @(posedge clk_in);
		pulse_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		pulse_out <= 1'b0;
	endtask : gap

	task automatic send_cmd(input logic [47:0] nibs, input int n);
		int slots;
		gap(1);
		// rise to rise is one whole slot
		gap(CAL - 1);
		for (int i = 0; i < n; i++) begin
			slots = int'(nibs[47-4*i -: 4]);
			gap(slots * (CAL + 1) + (CAL + 1) / 2 - 2);
		end
		// silence of more than 16 slots closes the frame
		repeat (18 * (CAL + 1)) @(posedge clk_in);
	endtask : send_cmd

	// first coded bit must be 1 so the first rise marks its start
	task automatic get_bits(input int n, output logic [159:0] bits,
			output logic ok, output int bad);
		int   k;
		logic h0;
		bits = '0;
		ok = 1'b0;
		bad = 0;
		k = 0;
		while (k < 20000 && modulate_in !== 1'b1) begin
			@(negedge clk_in);
			k++;
		end
		if (modulate_in !== 1'b1) return;
		ok = 1'b1;
		repeat (HALF / 2) @(negedge clk_in);
		for (int i = 0; i < n; i++) begin
			h0 = modulate_in;
			repeat (HALF) @(negedge clk_in);
			if (modulate_in === h0) bad++;
			bits = {bits[158:0], h0};
			repeat (HALF) @(negedge clk_in);
		end
	endtask : get_bits
endmodule : ptl_reader_model

// ===== verif/test_ptl_tag_core.sv
`define CHECK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end

module test_ptl_tag_core;
	timeunit 1ns;
	timeprecision 100ps;

	// arbitrary identifier; top bit set so answers start with a 1
	localparam logic [31:0] ID = 32'h8d3c_0f20;
	localparam logic [31:0] WD = 32'h9abc_def1;
	// both mode bits set, low bits clear
	localparam logic [31:0] CFG = 32'hc000_0000;

	logic                      clk_in = 1'b0;
	logic                      reset_in = 1'b1;
	logic                      pulse;
	ptl_pkg::ptl_bus_req_type  bus_q;
	logic [31:0]               rdata;
	logic                      mod;
	logic                      asleep;
	int                        n_fail = 0;
	int                        n_checks = 0;

	always #12.5 clk_in = ~clk_in;

	ptl_tag_core #(.LISTEN_CYCLES(2000), .TAG_ID(ID)) DUT (
		.clk_in            (clk_in),
		.reset_in          (reset_in),
		.downlink_pulse_in (pulse),
		.bus_in            (bus_q),
		.bus_rdata_out     (rdata),
		.modulate_out      (mod),
		.asleep_out        (asleep)
	);

	ptl_reader_model reader (
		.clk_in      (clk_in),
		.modulate_in (mod),
		.pulse_out   (pulse)
	);

	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		logic        fb;
		c = 16'hffff;
		for (int i = 31; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb) c = c ^ 16'h1021;
		end
		return c;
	endfunction : crc16

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus_q.wr <= 1'b1;
		bus_q.addr <= a;
		bus_q.wdata <= d;
		@(posedge clk_in);
		bus_q.wr <= 1'b0;
	endtask : bus_write

	task automatic check_reg(input logic [3:0] a, input logic [31:0] e,
			input logic [31:0] m, input string nm);
		logic [31:0] v;
		@(posedge clk_in);
		bus_q.rd <= 1'b1;
		bus_q.addr <= a;
		@(posedge clk_in);
		bus_q.rd <= 1'b0;
		@(negedge clk_in);
		v = rdata & m;
		`CHECK(nm, e, v)
	endtask : check_reg

	task automatic quiet(input int n, input string nm);
		int hits;
		hits = 0;
		repeat (n) begin
			@(negedge clk_in);
			if (mod !== 1'b0) hits++;
		end
		`CHECK(nm, 0, hits)
	endtask : quiet

	task automatic response(input logic [47:0] c, input int n, input int nb,
			input logic [159:0] e, input string nm);
		logic [159:0] b;
		logic         ok;
		int           bad;
		fork
			reader.send_cmd(c, n);
			reader.get_bits(nb, b, ok, bad);
		join
		`CHECK("answer start", 1'b1, ok)
		if (ok !== 1'b1) tally_and_finish();
		`CHECK("manchester halves", 0, bad)
		`CHECK(nm, e, b)
	endtask : response

	initial begin
		bus_q = '0;
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;

		check_reg(ptl_pkg::REG_STATUS, 32'h0, 32'h7, "idle state");
		bus_write(ptl_pkg::REG_SEL, 32'h1);
		check_reg(ptl_pkg::REG_DATA, ID, '1, "identifier");
		bus_write(ptl_pkg::REG_SEL, 32'h0);
		check_reg(ptl_pkg::REG_DATA, 32'h8000_0000, '1, "config");
		bus_write(4'h2, 32'hffff_ffff);
		check_reg(4'h2, 32'h0, '1, "unmapped read");
		bus_write(ptl_pkg::REG_SEL, 32'h1f);
		check_reg(ptl_pkg::REG_DATA, 32'h0, '1, "last block");
		$display("test reset_values done");

		quiet(400, "silent after reset");
		reader.send_cmd({ptl_pkg::OP_FAST_READ_BYPASS, 44'h0}, 1);
		quiet(1500, "bypass refused");
		check_reg(ptl_pkg::REG_STATUS, 32'h0, 32'h7, "still idle");
		$display("test request_mode done");

		// slot 0 forced, overrun cleared
		bus_write(ptl_pkg::REG_CTRL, 32'h0000_0110);
		response({ptl_pkg::OP_FAST_READ_REQUEST, 44'h0}, 1, 128,
			{32'h0, ID, 96'h0}, "fast read answer");
		reader.send_cmd({ptl_pkg::OP_SELECT_MATCH_CODE, 44'h0}, 1);
		check_reg(ptl_pkg::REG_STATUS, 32'h4, 32'h7, "selected");
		$display("test fast_read done");

		response({ptl_pkg::OP_WRITE_BLOCK, 8'h03, WD, 4'h0}, 11, 48,
			{112'h0, WD, crc16(WD)}, "write echo");
		bus_write(ptl_pkg::REG_SEL, 32'h3);
		check_reg(ptl_pkg::REG_DATA, WD, '1, "user block");
		$display("test write_block done");

		// config locked: only the two mode bits still take a write
		reader.send_cmd({ptl_pkg::OP_LOCK_BLOCK, 8'h00, 36'h0}, 3);
		response({ptl_pkg::OP_WRITE_BLOCK, 8'h00, 32'hc000_1234, 4'h0},
			11, 48, {112'h0, CFG, crc16(CFG)}, "locked echo");
		bus_write(ptl_pkg::REG_SEL, 32'h0);
		check_reg(ptl_pkg::REG_DATA, CFG, '1, "config bits");
		$display("test lock_config done");

		reader.send_cmd({ptl_pkg::OP_END, 44'h0}, 1);
		`CHECK("asleep flag", 1'b1, asleep)
		check_reg(ptl_pkg::REG_STATUS, 32'hd, 32'hf, "sleep state");
		reader.send_cmd({ptl_pkg::OP_FAST_READ_REQUEST, 44'h0}, 1);
		quiet(1500, "sleep ignores");
		$display("test sleep done");

		// field removal is the only wake-up; stored blocks outlive it
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		`CHECK("awake after reset", 1'b0, asleep)
		// mode bits now ask for an answer at power-up
		check_reg(ptl_pkg::REG_STATUS, 32'h2, 32'h7, "talks first");
		`CHECK("boot first half", 1'b1, mod)
		bus_write(ptl_pkg::REG_SEL, 32'h3);
		check_reg(ptl_pkg::REG_DATA, WD, '1, "kept block");
		$display("test wake done");

		tally_and_finish();
	end
endmodule : test_ptl_tag_core
